// ---- hw/ep_six_irq.sv ----
// endpoint-6 summary interrupt slice with AXI4-Lite register access
// assumes a single clock and sources synchronous to it
`timescale 1ns/100ps
`default_nettype none
module ep_six_irq
    import ep_six_irq_pkg::*;
#(
    parameter int addr_w = 8
) (
    input  wire logic              aclk,                    // clock
    input  wire logic              aresetn,                 // sync reset, low
    input  wire logic              transmit_complete,       // source
    input  wire logic              receive_out_bank_zero,   // source
    input  wire logic              receive_out_bank_one,    // source
    input  wire logic              setup_packet_received,   // source
    input  wire logic              stall_sent_or_crc_error, // source
    output logic                   usb_irq,                 // usb request
    output logic                   evt_irq,                 // event irq
    input  wire logic [addr_w-1:0] s_axi_awaddr,            // write addr
    input  wire logic [2:0]        s_axi_awprot,            // unused
    input  wire logic              s_axi_awvalid,           // aw valid
    output logic                   s_axi_awready,           // aw ready
    input  wire logic [31:0]       s_axi_wdata,             // write data
    input  wire logic [3:0]        s_axi_wstrb,             // byte enables
    input  wire logic              s_axi_wvalid,            // w valid
    output logic                   s_axi_wready,            // w ready
    output logic [1:0]             s_axi_bresp,             // write resp
    output logic                   s_axi_bvalid,            // b valid
    input  wire logic              s_axi_bready,            // b ready
    input  wire logic [addr_w-1:0] s_axi_araddr,            // read addr
    input  wire logic [2:0]        s_axi_arprot,            // unused
    input  wire logic              s_axi_arvalid,           // ar valid
    output logic                   s_axi_arready,           // ar ready
    output logic [31:0]            s_axi_rdata,             // read data
    output logic [1:0]             s_axi_rresp,             // read resp
    output logic                   s_axi_rvalid,            // r valid
    input  wire logic              s_axi_rready             // r ready
);
    logic [src_count-1:0] src;
    logic                 flag_ff;
    logic                 set_pulse;
    logic                 clr_pulse;
    logic [7:0]           enable_ff;
    logic [1:0]           mask_ff;
    logic [1:0]           status_ff;
    logic                 aw_held_ff;
    logic                 w_held_ff;
    logic [addr_w-1:0]    awaddr_ff;
    logic [31:0]          wdata_ff;
    logic [3:0]           wstrb_ff;
    logic                 aw_fire;
    logic                 w_fire;
    logic                 ar_fire;
    logic                 do_write;
    logic                 rd_status;
    logic [31:0]          rd_word;
    logic                 rd_hit;

    function automatic logic hit(input logic [addr_w-1:0] a,
                                 input logic [7:0] off);
        hit = (a[addr_w-1:2] == off[addr_w-1:2]);
    endfunction : hit

    function automatic logic mapped(input logic [addr_w-1:0] a);
        mapped = hit(a, summary_off) | hit(a, enable_off) |
                 hit(a, evt_status_off) | hit(a, evt_mask_off) |
                 hit(a, src_view_off);
    endfunction : mapped

    // order fixes the source view layout, bit 0 upward
    assign src = {stall_sent_or_crc_error, setup_packet_received,
                  receive_out_bank_one, receive_out_bank_zero,
                  transmit_complete};

    ep_six_flag_tracker u_flag (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .src       (src),
        .flag_ff   (flag_ff),
        .set_pulse (set_pulse),
        .clr_pulse (clr_pulse)
    );

    // both inputs are flops, so the request has no glitch
    assign usb_irq = flag_ff & enable_ff[flag_bit];
    assign evt_irq = |(status_ff & mask_ff);

    // write channel: address and data taken in either order
    assign s_axi_awready = ~aw_held_ff & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_ff & ~s_axi_bvalid;
    assign aw_fire       = s_axi_awvalid & s_axi_awready;
    assign w_fire        = s_axi_wvalid & s_axi_wready;
    assign do_write      = aw_held_ff & w_held_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= '0;
            wdata_ff   <= 32'h0;
            wstrb_ff   <= 4'h0;
        end else begin
            if (aw_fire) begin
                aw_held_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_ff <= 1'b0;
            end
            if (w_fire) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= resp_okay;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_ff) ? resp_okay : resp_slverr;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // only byte lane 0 carries register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_ff <= enable_rst;
            mask_ff   <= mask_rst;
        end else if (do_write && wstrb_ff[0]) begin
            if (hit(awaddr_ff, enable_off)) begin
                enable_ff <= wdata_ff[7:0];
            end
            if (hit(awaddr_ff, evt_mask_off)) begin
                mask_ff <= wdata_ff[evt_count-1:0];
            end
        end
    end

    // read channel, one read in flight
    assign s_axi_arready = ~s_axi_rvalid;
    assign ar_fire       = s_axi_arvalid & s_axi_arready;
    assign rd_status     = ar_fire & hit(s_axi_araddr, evt_status_off);

    always_comb begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        if (hit(s_axi_araddr, summary_off)) begin
            // summary writes are ignored; top bit is tied low
            rd_word[flag_bit]     = flag_ff;
            rd_word[reserved_bit] = 1'b0;
        end else if (hit(s_axi_araddr, enable_off)) begin
            rd_word[7:0] = enable_ff;
        end else if (hit(s_axi_araddr, evt_status_off)) begin
            rd_word[evt_count-1:0] = status_ff;
        end else if (hit(s_axi_araddr, evt_mask_off)) begin
            rd_word[evt_count-1:0] = mask_ff;
        end else if (hit(s_axi_araddr, src_view_off)) begin
            rd_word[src_count-1:0] = src;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= resp_okay;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? resp_okay : resp_slverr;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // read clears, but an edge in the same cycle survives the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_ff <= status_rst;
        end else begin
            status_ff <= (rd_status ? 2'h0 : status_ff) |
                         {clr_pulse, set_pulse};
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence src_active;
        |src;
    endsequence

    sequence src_quiet;
        ~|src;
    endsequence

    a_flag_sets: assert property (
        src_active |=> flag_ff)
        else $error("summary flag did not set on active source");

    a_source_set_exact: assert property (
        flag_ff |-> $past(|src))
        else $error("summary flag set without an endpoint source");

    a_irq_gated_enable: assert property (
        (flag_ff && !enable_ff[flag_bit]) |-> !usb_irq)
        else $error("usb request raised while endpoint enable clear");

    a_irq_follows_flag: assert property (
        (src_active ##1 enable_ff[flag_bit]) |-> usb_irq)
        else $error("usb request missing with flag and enable set");

    a_flag_clears: assert property (
        src_quiet ##1 src_quiet |-> !flag_ff ##1 !flag_ff)
        else $error("summary flag held after sources cleared");

    a_reserved_reads_zero: assert property (
        (ar_fire && hit(s_axi_araddr, summary_off))
            |=> s_axi_rvalid && !s_axi_rdata[reserved_bit])
        else $error("reserved summary bit read as one");

    a_event_sticky: assert property (
        (set_pulse && !rd_status) |=> status_ff[evt_set_bit] [*2]
            or (status_ff[evt_set_bit] ##1 $past(rd_status)))
        else $error("set event lost before being read");
endmodule : ep_six_irq
`default_nettype wire

// ---- hw/ep_six_irq_pkg.sv ----
// constants for the endpoint-6 summary interrupt slice
// assumes an AXI4-Lite master with 32-bit data and one clock domain
package ep_six_irq_pkg;
    // byte offsets, one aligned word each
    localparam logic [7:0] summary_off    = 8'h00;
    localparam logic [7:0] enable_off     = 8'h04;
    localparam logic [7:0] evt_status_off = 8'h08;
    localparam logic [7:0] evt_mask_off   = 8'h0c;
    localparam logic [7:0] src_view_off   = 8'h10;

    localparam int flag_bit     = 6;
    localparam int reserved_bit = 7;
    localparam int src_count    = 5;
    localparam int evt_set_bit  = 0;
    localparam int evt_clr_bit  = 1;
    localparam int evt_count    = 2;

    localparam logic [7:0] enable_rst = 8'h00;
    localparam logic [1:0] mask_rst   = 2'h0;
    localparam logic [1:0] status_rst = 2'h0;

    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage : ep_six_irq_pkg

// ---- hw/ep_six_flag_tracker.sv ----
// endpoint-6 summary flag follower with edge events
// assumes sources come from per-endpoint status logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module ep_six_flag_tracker
    import ep_six_irq_pkg::*;
(
    input  wire logic                 aclk,      // 250 MHz clock
    input  wire logic                 aresetn,   // sync reset, low
    input  wire logic [src_count-1:0] src,       // endpoint-6 sources
    output logic                      flag_ff,   // summary flag
    output logic                      set_pulse, // flag rose
    output logic                      clr_pulse  // flag fell
);
    logic nxt_flag;

    // set and clear are both hardware only; no software path exists
    assign nxt_flag = |src;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            set_pulse <= 1'b0;
            clr_pulse <= 1'b0;
        end else begin
            set_pulse <= nxt_flag & ~flag_ff;
            clr_pulse <= ~nxt_flag & flag_ff;
        end
    end
endmodule : ep_six_flag_tracker
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the endpoint-6 summary interrupt slice
// assumes the design files under hw/ are compiled first, one clock
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ep_six_irq_pkg::*;
    logic        aclk, aresetn, usb_irq, evt_irq;
    logic [4:0]  src;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          error_cnt, n_tests, cyc;

    ep_six_irq i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .transmit_complete(src[0]), .receive_out_bank_zero(src[1]),
        .receive_out_bank_one(src[2]), .setup_packet_received(src[3]),
        .stall_sent_or_crc_error(src[4]),
        .usb_irq(usb_irq), .evt_irq(evt_irq),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            $display("timeout reached");
            close_out();
        end
    end

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask : idle

    // readies sampled in the active region see the pre-edge values
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        bit aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1 && aw_done && w_done) begin
                bready <= 1'b0;
                check("bresp", {30'h0, bresp}, {30'h0, er});
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] er, input string nm);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1 && !arvalid) begin
                rready <= 1'b0;
                check(nm, rdata, exp);
                check("rresp", {30'h0, rresp}, {30'h0, er});
                break;
            end
        end
    endtask : rd

    initial begin
        aresetn = 1'b0;
        src = 5'h00;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        error_cnt = 0;
        n_tests = 0;
        cyc = 0;
        idle(12);
        aresetn <= 1'b1;
        idle(1);
        rd(summary_off, 32'h0, resp_okay, "summary");
        rd(enable_off, {24'h0, enable_rst}, resp_okay, "enable");
        rd(evt_mask_off, {30'h0, mask_rst}, resp_okay, "mask");
        rd(evt_status_off, {30'h0, status_rst}, resp_okay, "status");
        $display("test reset values done");
        for (int i = 0; i < src_count; i++) begin
            src <= 5'h01 << i;
            idle(3);
            rd(summary_off, 32'h40, resp_okay, "summary");
            rd(src_view_off, 32'h1 << i, resp_okay, "view");
            check("usb_irq", {31'h0, usb_irq}, 32'h0);
            src <= 5'h00;
            idle(3);
            rd(summary_off, 32'h0, resp_okay, "summary");
        end
        $display("test each source done");
        wr(enable_off, 32'h40, resp_okay);
        rd(enable_off, 32'h40, resp_okay, "enable");
        src <= 5'h10;
        idle(3);
        check("usb_irq", {31'h0, usb_irq}, 32'h1);
        // software must not clear the flag nor set bits 0 to 5
        wr(summary_off, 32'h7f, resp_okay);
        rd(summary_off, 32'h40, resp_okay, "summary");
        check("usb_irq", {31'h0, usb_irq}, 32'h1);
        wr(enable_off, 32'h00, resp_okay);
        idle(1);
        check("usb_irq", {31'h0, usb_irq}, 32'h0);
        src <= 5'h00;
        idle(3);
        $display("test enable and reserved done");
        rd(evt_status_off, 32'h3, resp_okay, "status");
        rd(evt_status_off, 32'h0, resp_okay, "status");
        wr(evt_mask_off, 32'h1, resp_okay);
        src <= 5'h08;
        idle(3);
        check("evt_irq", {31'h0, evt_irq}, 32'h1);
        rd(evt_status_off, 32'h1, resp_okay, "status");
        idle(1);
        check("evt_irq", {31'h0, evt_irq}, 32'h0);
        src <= 5'h00;
        idle(3);
        check("evt_irq", {31'h0, evt_irq}, 32'h0);
        rd(evt_status_off, 32'h2, resp_okay, "status");
        // mask bit 1 lets only the falling edge of the flag through
        wr(evt_mask_off, 32'h2, resp_okay);
        src <= 5'h04;
        idle(3);
        check("evt_irq", {31'h0, evt_irq}, 32'h0);
        src <= 5'h00;
        idle(3);
        check("evt_irq", {31'h0, evt_irq}, 32'h1);
        rd(evt_status_off, 32'h3, resp_okay, "status");
        idle(1);
        check("evt_irq", {31'h0, evt_irq}, 32'h0);
        $display("test events done");
        // mid-run reset with a source held on: enable and mask return to 0
        wr(enable_off, 32'h40, resp_okay);
        wr(evt_mask_off, 32'h3, resp_okay);
        src <= 5'h02;
        idle(3);
        check("usb_irq", {31'h0, usb_irq}, 32'h1);
        aresetn <= 1'b0;
        idle(2);
        aresetn <= 1'b1;
        idle(1);
        check("usb_irq", {31'h0, usb_irq}, 32'h0);
        check("evt_irq", {31'h0, evt_irq}, 32'h0);
        rd(enable_off, {24'h0, enable_rst}, resp_okay, "enable");
        rd(evt_mask_off, {30'h0, mask_rst}, resp_okay, "mask");
        rd(summary_off, 32'h40, resp_okay, "summary");
        src <= 5'h00;
        idle(3);
        rd(summary_off, 32'h0, resp_okay, "summary");
        $display("test mid-run reset done");
        rd(8'h20, 32'h0, resp_slverr, "unmapped");
        wr(8'h20, 32'h40, resp_slverr);
        rd(enable_off, 32'h0, resp_okay, "enable");
        $display("test unmapped done");
        close_out();
    end
endmodule : testbench
`default_nettype wire
